// ---- src/adc_cfg_regs.vh ----
`ifndef ADC_CFG_REGS_VH
`define ADC_CFG_REGS_VH

// register locations, as seen in the target_select code
`define ADDR_GLOBAL_CONTROL 4'h0
`define ADDR_CCR_BLOCK_LOW 4'h4
`define ADDR_CCR_BLOCK_HIGH 4'h8

// command_byte fields
`define IR_DIR 7
`define IR_NB_HI 6
`define IR_NB_LO 5
`define IR_RB 4
`define IR_TGT_HI 3
`define IR_TGT_LO 2
`define IR_SUB_HI 1
`define IR_SUB_LO 0

// target_select upper pair
`define TGT_CR 2'h0
`define TGT_CCR_LOW 2'h1
`define TGT_CCR_HIGH 2'h2
`define TGT_RAM 2'h3

// RAM codes in target_select lower pair
`define RAM_DATA 2'h0
`define RAM_OFFSET 2'h1
`define RAM_POS 2'h2
`define RAM_NEG 2'h3

// global_control fields
`define CR_RSV_HI 15
`define CR_RSV_LO 13
`define CR_CHOP 12
`define CR_SUPPRESS 11
`define CR_LNR 10
`define CR_FREQ 9
`define CR_TWOS 8
`define CR_CNT_HI 7
`define CR_CNT_LO 5
`define CR_TWOPT 4
`define CR_SLEEP 3
`define CR_BDIR 2
`define CR_LSBF 1
`define CR_WIRE 0
`define CR_RESET 16'h0000
`define CR_RSV_ZERO 3'h0

// channel_config byte fields
`define CFG_SEL_HI 7
`define CFG_SEL_LO 5
`define CFG_POL 4
`define CFG_MODE_HI 3
`define CFG_MODE_LO 2
`define CFG_GAIN_HI 1
`define CFG_GAIN_LO 0
`define CCR_RESET 32'h0000_0000
`define MODE_CONVERT 2'h0
`define GAIN_UNIT 4'h1

// sequencing counts
`define LAST_BIT 3'h7
`define LNR_SCANS 3'h4
`define PLAIN_SCANS 3'h1
`define FIRST_LOGICAL 3'h0
`define SYNC_WIDTH 4
// idle pin levels: rstIoN high, csN high, data low, sclk low
`define SYNC_RESET 4'hC

`endif

// ---- src/serial_pin_sync.v ----
`timescale 1ns/100ps
`default_nettype none

module serial_pin_sync #(
  parameter WIDTH = 4,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b1}}
) (
  // clock and reset
  input wire clk,
  input wire rstn,
  input wire ce,
  // raw pins
  input wire [WIDTH-1:0] pinIn,
  // synchronised levels and edges
  output wire [WIDTH-1:0] level,
  output wire [WIDTH-1:0] rise,
  output wire [WIDTH-1:0] fall
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg meta_r;
      reg stable_r;
      reg prev_r;
      // first stage feeds only the second stage
      always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          meta_r <= RESET_VAL[i];
          stable_r <= RESET_VAL[i];
          prev_r <= RESET_VAL[i];
        end else if (ce) begin
          meta_r <= pinIn[i];
          stable_r <= meta_r;
          prev_r <= stable_r;
        end
      end
      assign level[i] = stable_r;
      assign rise[i] = stable_r & ~prev_r;
      assign fall[i] = ~stable_r & prev_r;
    end
  endgenerate

endmodule // serial_pin_sync

`default_nettype wire

// ---- src/adc_serial_config_register_bank.v ----
`timescale 1ns/100ps
`default_nettype none
`include "adc_cfg_regs.vh"

module adc_serial_config_register_bank (
  // clock, reset, enable
  input wire clk,
  input wire rstn,
  input wire ce,
  // serial port pins
  input wire sclk,
  input wire csN,
  input wire rstIoN,
  input wire sdioIn,
  output wire sdioOut,
  output wire sdioOeN,
  output wire serialOutLine,
  output wire serialOutOeN,
  // converter datapath events
  input wire convStep,
  input wire calDone,
  // chip-level settings
  output wire chopBypass,
  output wire scanFlagSuppress,
  output wire lineNoiseFilterEn,
  output wire mainsFreqSelect,
  output wire twosComplementSel,
  output wire [2:0] activeChannelCount,
  output wire twoPointCal,
  output wire sleepRequest,
  output wire [63:0] channelConfig,
  // sequencing status
  output wire converting,
  output wire filterClear,
  output wire scanDoneN,
  output wire calActive,
  output wire [2:0] convPointer,
  output wire [2:0] curInputPair,
  output wire curBipolar,
  output wire [1:0] curOpMode,
  output wire [3:0] curGain,
  output wire twosCompActive,
  // RAM access requests
  output wire ramReq,
  output wire ramWrite,
  output wire [1:0] ramSel,
  output wire ramByteOrder
);

  localparam ST_INSTR = 2'h0;
  localparam ST_WRITE = 2'h1;
  localparam ST_READ = 2'h2;
  localparam ST_BURST = 2'h3;

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisation

  wire [`SYNC_WIDTH-1:0] pinLevel;
  wire [`SYNC_WIDTH-1:0] pinRise;
  wire [`SYNC_WIDTH-1:0] pinFall;

  serial_pin_sync #(
    .WIDTH(`SYNC_WIDTH),
    .RESET_VAL(`SYNC_RESET)
  ) u_sync (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .pinIn({rstIoN, csN, sdioIn, sclk}),
    .level(pinLevel),
    .rise(pinRise),
    .fall(pinFall)
  );

  wire sclkRise = pinRise[0];
  wire sclkFall = pinFall[0];
  wire dataIn = pinLevel[1];
  wire selected = ~pinLevel[2];
  wire ioReset = ~pinLevel[3];

  //////////////////////////////////////////////////////////////////////////////
  // register storage

  reg [15:0] crReg_r;
  reg [31:0] ccrLow_r;
  reg [31:0] ccrHigh_r;

  wire lsbFirst = crReg_r[`CR_LSBF];
  wire ascending = crReg_r[`CR_BDIR];
  wire threeWire = crReg_r[`CR_WIRE];
  wire sleepBit = crReg_r[`CR_SLEEP];
  wire lnrOn = crReg_r[`CR_LNR];
  wire [2:0] lastLogical = crReg_r[`CR_CNT_HI:`CR_CNT_LO];

  //////////////////////////////////////////////////////////////////////////////
  // logical channel view of the config store

  wire [63:0] logicalCfg;
  wire [7:0] calPending;

  genvar k;
  generate
    for (k = 0; k < 8; k = k + 1) begin : g_logical
      wire [7:0] cfgByte;
      // keeps every part-select inside its block
      if (k < 4) begin : g_hi
        assign cfgByte = ccrHigh_r[8*(3-k) +: 8];
      end else begin : g_lo
        assign cfgByte = ccrLow_r[8*(7-k) +: 8];
      end
      assign logicalCfg[8*k +: 8] = cfgByte;
      assign calPending[k] = (k <= lastLogical) &&
        (cfgByte[`CFG_MODE_HI:`CFG_MODE_LO] != `MODE_CONVERT);
    end
  endgenerate

  wire anyCal = |calPending;

  //////////////////////////////////////////////////////////////////////////////
  // serial engine state

  reg [1:0] state_r;
  reg [2:0] bitCnt_r;
  reg [7:0] rxSh_r;
  reg [7:0] txSh_r;
  reg [1:0] tgt_r;
  reg [1:0] byteIdx_r;
  reg [1:0] bytesLeft_r;
  reg sdioOut_r;
  reg sdioOeN_r;
  reg serialOut_r;
  reg serialOutOeN_r;
  reg ramReq_r;
  reg ramWrite_r;
  reg [1:0] ramSel_r;
  reg ramByteOrder_r;
  reg dataRamRead_r;

  wire [7:0] rxNext = lsbFirst ? {dataIn, rxSh_r[7:1]} : {rxSh_r[6:0], dataIn};
  wire byteDone = sclkRise && (bitCnt_r == `LAST_BIT);

  // register byte read mux
  function [7:0] regByte;
    input [1:0] tgt;
    input [1:0] idx;
    begin
      case (tgt)
        `TGT_CR: regByte = idx[0] ? crReg_r[15:8] : crReg_r[7:0];
        `TGT_CCR_LOW: regByte = ccrLow_r[{idx, 3'b000} +: 8];
        `TGT_CCR_HIGH: regByte = ccrHigh_r[{idx, 3'b000} +: 8];
        default: regByte = 8'h00;
      endcase
    end
  endfunction

  // next byte position, wrapping inside the register
  function [1:0] stepIdx;
    input [1:0] tgt;
    input [1:0] idx;
    input up;
    begin
      if (tgt == `TGT_CR) begin
        stepIdx = {1'b0, ~idx[0]};
      end else if (up) begin
        stepIdx = idx + 2'h1;
      end else begin
        stepIdx = idx - 2'h1;
      end
    end
  endfunction

  wire [1:0] cmdTgt = rxNext[`IR_TGT_HI:`IR_TGT_LO];
  // control register has only byte 0 and 1
  wire [1:0] cmdStart = (cmdTgt == `TGT_CR) ? {1'b0, rxNext[`IR_SUB_LO]} :
    rxNext[`IR_SUB_HI:`IR_SUB_LO];
  wire [1:0] nextIdx = stepIdx(tgt_r, byteIdx_r, ascending);

  wire wrByte = (state_r == ST_WRITE) && byteDone && selected;

  //////////////////////////////////////////////////////////////////////////////
  // serial engine

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_INSTR;
      bitCnt_r <= 3'h0;
      rxSh_r <= 8'h00;
      txSh_r <= 8'h00;
      tgt_r <= `TGT_CR;
      byteIdx_r <= 2'h0;
      bytesLeft_r <= 2'h0;
      ramReq_r <= 1'b0;
      ramWrite_r <= 1'b0;
      ramSel_r <= `RAM_DATA;
      ramByteOrder_r <= 1'b0;
      dataRamRead_r <= 1'b0;
    end else if (ce) begin
      ramReq_r <= 1'b0;
      dataRamRead_r <= 1'b0;
      if (ioReset) begin
        state_r <= ST_INSTR;
        bitCnt_r <= 3'h0;
      end else if (selected && sclkRise) begin
        // suspended while deselected, resumes on reselect
        bitCnt_r <= bitCnt_r + 3'h1;
        rxSh_r <= rxNext;
        if (bitCnt_r == `LAST_BIT) begin
          case (state_r)
            ST_INSTR: begin
              tgt_r <= cmdTgt;
              byteIdx_r <= cmdStart;
              bytesLeft_r <= rxNext[`IR_NB_HI:`IR_NB_LO];
              txSh_r <= regByte(cmdTgt, cmdStart);
              if (cmdTgt == `TGT_RAM) begin
                // RAM select, data RAM never written
                ramReq_r <= 1'b1;
                ramSel_r <= rxNext[`IR_SUB_HI:`IR_SUB_LO];
                ramWrite_r <= rxNext[`IR_DIR] && (rxNext[`IR_SUB_HI:`IR_SUB_LO] != `RAM_DATA);
                ramByteOrder_r <= rxNext[`IR_RB];
                dataRamRead_r <= !rxNext[`IR_DIR] && (rxNext[`IR_SUB_HI:`IR_SUB_LO] == `RAM_DATA);
                state_r <= ST_BURST;
              end else if (rxNext[`IR_DIR]) begin
                state_r <= ST_WRITE;
              end else begin
                state_r <= ST_READ;
              end
            end
            ST_WRITE, ST_READ: begin
              byteIdx_r <= nextIdx;
              bytesLeft_r <= bytesLeft_r - 2'h1;
              txSh_r <= regByte(tgt_r, nextIdx);
              if (bytesLeft_r == 2'h0) begin
                state_r <= ST_INSTR;
              end
            end
            ST_BURST: state_r <= ST_BURST;
            default: state_r <= ST_INSTR;
          endcase
        end
      end else if (selected && sclkFall && state_r == ST_READ) begin
        txSh_r <= lsbFirst ? {1'b0, txSh_r[7:1]} : {txSh_r[6:0], 1'b0};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // data pins: driven on falling sclk

  wire reading = selected && (state_r == ST_READ) && !ioReset;
  wire txBit = lsbFirst ? txSh_r[0] : txSh_r[7];

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sdioOut_r <= 1'b0;
      sdioOeN_r <= 1'b1;
      serialOut_r <= 1'b0;
      serialOutOeN_r <= 1'b1;
    end else if (ce) begin
      if (sclkFall && reading) begin
        sdioOut_r <= txBit;
        serialOut_r <= txBit;
      end
      sdioOeN_r <= !(reading && !threeWire);
      serialOutOeN_r <= !(reading && threeWire);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // configuration registers

  reg [2:0] convPtr_r;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      crReg_r <= `CR_RESET;
      ccrLow_r <= `CCR_RESET;
      ccrHigh_r <= `CCR_RESET;
    end else if (ce) begin
      if (wrByte && tgt_r == `TGT_CR && byteIdx_r[0]) begin
        crReg_r[15:8] <= rxNext;
      end
      if (wrByte && tgt_r == `TGT_CR && !byteIdx_r[0]) begin
        crReg_r[7:0] <= rxNext;
      end
      if (wrByte && tgt_r == `TGT_CCR_LOW) begin
        ccrLow_r[{byteIdx_r, 3'b000} +: 8] <= rxNext;
      end
      if (wrByte && tgt_r == `TGT_CCR_HIGH) begin
        ccrHigh_r[{byteIdx_r, 3'b000} +: 8] <= rxNext;
      end
      if (calDone && !sleepBit && !convPtr_r[2]) begin
        ccrHigh_r[{~convPtr_r[1:0], 3'b010} +: 2] <= `MODE_CONVERT;
      end
      if (calDone && !sleepBit && convPtr_r[2]) begin
        ccrLow_r[{~convPtr_r[1:0], 3'b010} +: 2] <= `MODE_CONVERT;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // scan sequencing

  reg [2:0] scans_r;
  reg scanDoneN_r;
  reg converting_r;
  reg filterClear_r;
  reg calActive_r;
  reg [7:0] curCfg_r;
  reg [3:0] curGain_r;
  reg twosCompActive_r;

  wire [2:0] scansNeeded = lnrOn ? `LNR_SCANS : `PLAIN_SCANS;
  wire scanEnd = convStep && !sleepBit && (convPtr_r == lastLogical);
  wire [2:0] scansNext = (scans_r == scansNeeded) ? scans_r : scans_r + 3'h1;
  wire eosFire = scanEnd && (scansNext >= scansNeeded);
  wire eosBlocked = crReg_r[`CR_SUPPRESS] && anyCal;
  wire [7:0] ptrCfg = logicalCfg[{convPtr_r, 3'b000} +: 8];

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      convPtr_r <= `FIRST_LOGICAL;
      scans_r <= 3'h0;
      scanDoneN_r <= 1'b1;
      converting_r <= 1'b0;
      filterClear_r <= 1'b1;
      calActive_r <= 1'b0;
      curCfg_r <= 8'h00;
      curGain_r <= `GAIN_UNIT;
      twosCompActive_r <= 1'b0;
    end else if (ce) begin
      converting_r <= !sleepBit;
      filterClear_r <= sleepBit;
      calActive_r <= anyCal;
      curCfg_r <= ptrCfg;
      curGain_r <= `GAIN_UNIT << ptrCfg[`CFG_GAIN_HI:`CFG_GAIN_LO];
      // two's complement only for bipolar channels
      twosCompActive_r <= crReg_r[`CR_TWOS] && ptrCfg[`CFG_POL];
      if (sleepBit) begin
        convPtr_r <= `FIRST_LOGICAL;
        scans_r <= 3'h0;
        scanDoneN_r <= 1'b1;
      end else begin
        if (convStep) begin
          convPtr_r <= (convPtr_r == lastLogical) ? `FIRST_LOGICAL : convPtr_r + 3'h1;
        end
        if (scanEnd) begin
          scans_r <= scansNext;
        end
        // new scan beats a data RAM read in the same cycle
        if (eosFire && !eosBlocked) begin
          scanDoneN_r <= 1'b0;
        end else if (dataRamRead_r) begin
          scanDoneN_r <= 1'b1;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign sdioOut = sdioOut_r;
  assign sdioOeN = sdioOeN_r;
  assign serialOutLine = serialOut_r;
  assign serialOutOeN = serialOutOeN_r;
  assign chopBypass = crReg_r[`CR_CHOP];
  assign scanFlagSuppress = crReg_r[`CR_SUPPRESS];
  assign lineNoiseFilterEn = crReg_r[`CR_LNR];
  assign mainsFreqSelect = crReg_r[`CR_FREQ];
  assign twosComplementSel = crReg_r[`CR_TWOS];
  assign activeChannelCount = crReg_r[`CR_CNT_HI:`CR_CNT_LO];
  assign twoPointCal = crReg_r[`CR_TWOPT];
  assign sleepRequest = crReg_r[`CR_SLEEP];
  assign channelConfig = {ccrHigh_r, ccrLow_r};
  assign converting = converting_r;
  assign filterClear = filterClear_r;
  assign scanDoneN = scanDoneN_r;
  assign calActive = calActive_r;
  assign convPointer = convPtr_r;
  // code n is input pair n plus one
  assign curInputPair = curCfg_r[`CFG_SEL_HI:`CFG_SEL_LO];
  assign curBipolar = curCfg_r[`CFG_POL];
  assign curOpMode = curCfg_r[`CFG_MODE_HI:`CFG_MODE_LO];
  assign curGain = curGain_r;
  assign twosCompActive = twosCompActive_r;
  assign ramReq = ramReq_r;
  assign ramWrite = ramWrite_r;
  assign ramSel = ramSel_r;
  assign ramByteOrder = ramByteOrder_r;

endmodule // adc_serial_config_register_bank

`default_nettype wire

// ---- verification/host_serial_model.sv ----
`timescale 1ns/100ps
`default_nettype none

module host_serial_model (
  // serial clock and select
  output logic sclk,
  output logic csN,
  // data lines
  output wire logic sdioIn,
  input wire logic sdioOut,
  input wire logic sdioOeN,
  input wire logic serialOutLine,
  input wire logic serialOutOeN
);
  logic lsbFirst = 1'b0;
  logic threeWire = 1'b0;
  logic hostDrv = 1'b0;

  initial begin
    sclk = 1'b0;
    csN = 1'b1;
  end

  assign sdioIn = !sdioOeN ? sdioOut : hostDrv;

  //////////////////////////////
  // clock idles low, low half long enough for the output sync lag
  task automatic xfer(input logic [7:0] tx, input logic rd, output logic [7:0] rx);
    logic b;
    for (int i = 0; i < 8; i++) begin
      hostDrv = rd ? ~hostDrv : (lsbFirst ? tx[i] : tx[7 - i]);
      #500;
      b = threeWire ? (serialOutOeN ? 1'bz : serialOutLine) : (sdioOeN ? 1'bz : sdioOut);
      rx = lsbFirst ? {b, rx[7:1]} : {rx[6:0], b};
      sclk = 1'b1;
      #300;
      sclk = 1'b0;
    end
  endtask

  task automatic frame(input logic [7:0] cmd, input int n, input logic [31:0] wd, output logic [31:0] rd);
    logic [7:0] r;
    csN = 1'b0;
    #200;
    xfer(cmd, 1'b0, r);
    for (int k = 0; k < n; k++) begin
      xfer(wd[8 * k +: 8], !cmd[7], r);
      rd[8 * k +: 8] = r;
    end
    #200;
    csN = 1'b1;
    #300;
  endtask
endmodule // host_serial_model

`default_nettype wire

// ---- verification/adc_cfg_sva.sv ----
`timescale 1ns/100ps
`default_nettype none

module adc_cfg_sva (
  // clock and reset
  input wire clk,
  input wire rstn,
  // sequencing
  input wire convStep,
  input wire scanFlagSuppress,
  input wire twosComplementSel,
  input wire sleepRequest,
  input wire converting,
  input wire scanDoneN,
  input wire calActive,
  input wire curBipolar,
  input wire twosCompActive,
  input wire [2:0] activeChannelCount,
  input wire [2:0] convPointer,
  input wire [2:0] curInputPair,
  input wire [3:0] curGain,
  input wire [63:0] channelConfig,
  // RAM requests
  input wire ramReq,
  input wire ramWrite,
  input wire [1:0] ramSel
);
  // logical k sits at the same place in both blocks
  wire [7:0] ptrByte = channelConfig[63 - 8 * convPointer -: 8];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_asleep;
    sleepRequest ##1 sleepRequest;
  endsequence
  sequence s_stepTaken;
    convStep && !sleepRequest && convPointer <= activeChannelCount;
  endsequence

  property p_sleepStop;
    s_asleep |-> !converting && convPointer == 3'h0 && scanDoneN;
  endproperty
  a_sleepStop: assert property (p_sleepStop) else $error("sleep left sequencing running");
  property p_ptrAdvance;
    s_stepTaken |=> convPointer == ($past(convPointer) == $past(activeChannelCount) ? 3'h0 : $past(convPointer) + 3'h1);
  endproperty
  a_ptrAdvance: assert property (p_ptrAdvance) else $error("pointer step wrong");
  property p_curFields;
    $stable(convPointer) && $stable(ptrByte) |->
      curInputPair == ptrByte[7:5] && curBipolar == ptrByte[4] && curGain == 4'h1 << ptrByte[1:0];
  endproperty
  a_curFields: assert property (p_curFields) else $error("current channel fields wrong");
  property p_twosComp;
    $stable(twosComplementSel) && $stable(curBipolar) |-> twosCompActive == (twosComplementSel && curBipolar);
  endproperty
  a_twosComp: assert property (p_twosComp) else $error("coding select wrong");
  property p_doneCause;
    $fell(scanDoneN) |-> $past(convStep) && !$past(sleepRequest);
  endproperty
  a_doneCause: assert property (p_doneCause) else $error("end of scan without a step");
  property p_suppress;
    $fell(scanDoneN) |-> !($past(scanFlagSuppress) && $past(calActive) && $past(calActive, 2));
  endproperty
  a_suppress: assert property (p_suppress) else $error("end of scan during calibration");
  property p_ramRo;
    ramReq && ramSel == 2'h0 |-> !ramWrite;
  endproperty
  a_ramRo: assert property (p_ramRo) else $error("data store write accepted");
  property p_scanClear;
    ramReq && ramSel == 2'h0 && !ramWrite |-> ##[1:2] scanDoneN;
  endproperty
  a_scanClear: assert property (p_scanClear) else $error("data read left end of scan");
  property p_ramPulse;
    ramReq |=> !ramReq;
  endproperty
  a_ramPulse: assert property (p_ramPulse) else $error("store request too long");
endmodule // adc_cfg_sva

bind adc_serial_config_register_bank adc_cfg_sva adc_cfg_sva_inst (.clk, .rstn, .convStep, .scanFlagSuppress,
  .twosComplementSel, .sleepRequest, .converting, .scanDoneN, .calActive, .curBipolar, .twosCompActive,
  .activeChannelCount, .convPointer, .curInputPair, .curGain, .channelConfig, .ramReq, .ramWrite, .ramSel);

`default_nettype wire

// ---- verification/adc_serial_config_register_bank_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "adc_cfg_regs.vh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin failCount++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end

module adc_serial_config_register_bank_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic rstIoN = 1'b1;
  logic ce = 1'b1;
  logic convStep = 1'b0;
  logic calDone = 1'b0;
  int checks = 0;
  int failCount = 0;
  int s;
  logic [15:0] cr = 16'h0000;
  logic [63:0] channel_config = 64'h0000_0000_0000_0000;
  logic [31:0] rd;
  logic [3:0] t;
  logic [2:0] c;
  logic rb;
  wire sclk, csN, sdioIn, sdioOut, sdioOeN, serialOutLine, serialOutOeN;
  wire chopBypass, scanFlagSuppress, lineNoiseFilterEn, mainsFreqSelect, twosComplementSel, twoPointCal;
  wire sleepRequest, converting, filterClear, scanDoneN, calActive, curBipolar, twosCompActive;
  wire ramReq, ramWrite, ramByteOrder;
  wire [1:0] curOpMode, ramSel;
  wire [2:0] activeChannelCount, convPointer, curInputPair;
  wire [3:0] curGain;
  wire [63:0] channelConfig;
  wire [9:0] ctl = {chopBypass, scanFlagSuppress, lineNoiseFilterEn, mainsFreqSelect, twosComplementSel,
    activeChannelCount, twoPointCal, sleepRequest};

  always #50 clk = ~clk;

  adc_serial_config_register_bank adc_serial_config_register_bank_inst (.clk, .rstn, .ce, .sclk, .csN,
    .rstIoN, .sdioIn, .sdioOut, .sdioOeN, .serialOutLine, .serialOutOeN, .convStep, .calDone, .chopBypass,
    .scanFlagSuppress, .lineNoiseFilterEn, .mainsFreqSelect, .twosComplementSel, .activeChannelCount,
    .twoPointCal, .sleepRequest, .channelConfig, .converting, .filterClear, .scanDoneN, .calActive,
    .convPointer, .curInputPair, .curBipolar, .curOpMode, .curGain, .twosCompActive, .ramReq, .ramWrite,
    .ramSel, .ramByteOrder);

  host_serial_model host_inst (.sclk, .csN, .sdioIn, .sdioOut, .sdioOeN, .serialOutLine, .serialOutOeN);

  //////////////////////////////
  // bit offset of the k-th byte moved; control reg toggles, blocks wrap
  function automatic int off(input logic [3:0] tg, input int k);
    int b;
    b = tg[3:2] == `TGT_CR ? (tg[0] ^ k[0]) : ((tg[1:0] + (cr[`CR_BDIR] ? k : 4 - k)) % 4);
    return 8 * b + (tg[3] ? 32 : 0);
  endfunction

  function automatic int scansNeeded(input logic line_noise_filter_en, input logic [2:0] cnt);
    return (line_noise_filter_en ? 4 : 1) * (cnt + 1);
  endfunction

  // write then read back in one shape; format bits change only on request
  task automatic acc(input logic [3:0] tg, input int n, input logic useV, input logic [7:0] v);
    logic [31:0] wd;
    logic [7:0] b;
    logic r;
    int o;
    r = 1'($urandom);
    for (int k = 0; k < n; k++) begin
      o = off(tg, k);
      b = useV ? v : 8'($urandom);
      if (tg[3:2] == `TGT_CR && !useV) b = o ? b & 8'h1f : {b[7:4], cr[3:0]};
      if (tg[3:2] == `TGT_CR) cr[o +: 8] = b;
      else channel_config[o +: 8] = b;
      wd[8 * k +: 8] = b;
    end
    host_inst.frame({1'b1, 2'(n - 1), r, tg}, n, wd, rd);
    host_inst.lsbFirst = cr[`CR_LSBF];
    host_inst.threeWire = cr[`CR_WIRE];
    host_inst.frame({1'b0, 2'(n - 1), ~r, tg}, n, wd, rd);
    for (int k = 0; k < n; k++) `CHK("readback", wd[8 * k +: 8], rd[8 * k +: 8])
    `CHK("control", cr[12:3], ctl)
    `CHK("config", channel_config, channelConfig)
  endtask

  task automatic ioReset;
    @(posedge clk);
    #5 rstIoN = 1'b0;
    repeat (4) @(posedge clk);
    #5 rstIoN = 1'b1;
    repeat (4) @(posedge clk);
  endtask

  task automatic scan(input int n, input logic done);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      #5 convStep = 1'b1;
      @(posedge clk);
      #5 convStep = 1'b0;
      @(posedge clk);
    end
    #5 `CHK("scanDoneN", !done, scanDoneN)
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", checks, failCount);
    if (failCount == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  //////////////////////////////
  initial begin
    #9_000_000;
    failCount++;
    results();
  end

  initial begin
    rb = 1'($urandom(79051));
    repeat (10) @(posedge clk);
    #5 rstn = 1'b1;
    repeat (3) @(posedge clk);
    `CHK("control", 10'h000, ctl)
    `CHK("config", channel_config, channelConfig)
    host_inst.frame(8'h20, 2, 32'h0, rd);
    `CHK("crReset", 16'h0000, rd[15:0])
    for (int i = 0; i < 16; i++) begin
      s = $urandom_range(2);
      t = {s[1:0], 2'($urandom)};
      if (s == 0) t[1] = 1'b0;
      acc(t, s ? $urandom_range(4, 1) : $urandom_range(2, 1), 1'b0, 8'h00);
    end
    // every bit order, byte step and wire mode
    for (int f = 0; f < 8; f++) begin
      acc(4'h0, 1, 1'b1, {cr[7:4], 1'b0, 3'(f)});
      acc(4'hB, 4, 1'b0, 8'h00);
      acc(4'h4, 3, 1'b0, 8'h00);
    end
    for (int i = 0; i < 8; i++) begin
      rb = 1'($urandom);
      host_inst.frame({i[0], 2'($urandom), rb, 2'h3, i[2:1]}, 0, 32'h0, rd);
      repeat (3) @(posedge clk);
      `CHK("ram", {i[2:1], i[0] && i[2:1] != 2'h0, rb}, {ramSel, ramWrite, ramByteOrder})
      ioReset();
    end
    for (int l = 0; l < 2; l++) begin
      c = 3'($urandom);
      acc(4'h1, 1, 1'b1, {5'h00, l[0], 2'h0});
      acc(4'h0, 1, 1'b1, {c, 2'h1, cr[2:0]});
      acc(4'h0, 1, 1'b1, {c, 2'h0, cr[2:0]});
      scan(scansNeeded(l[0], c) - 1, 1'b0);
      scan(1, 1'b1);
      if (l == 0) begin
        host_inst.frame(8'h0C, 0, 32'h0, rd);
        ioReset();
        `CHK("scanDoneN", 1'b1, scanDoneN)
      end else begin
        acc(4'h0, 1, 1'b1, {c, 2'h1, cr[2:0]});
        `CHK("scanDoneN", 1'b1, scanDoneN)
        `CHK("sleepOut", 2'h1, {converting, filterClear})
      end
    end
    // calibration on the only active channel and on an idle one
    acc(4'h1, 1, 1'b1, 8'h08);
    acc(4'hB, 1, 1'b1, 8'h04);
    acc(4'hA, 1, 1'b1, 8'h04);
    acc(4'h0, 1, 1'b1, {5'h00, cr[2:0]});
    scan(1, 1'b0);
    `CHK("calMode", 3'h5, {calActive, curOpMode})
    // frozen clock enable must ignore a calibration end
    ce = 1'b0;
    calDone = 1'b1;
    repeat (2) @(posedge clk);
    #5 calDone = 1'b0;
    ce = 1'b1;
    `CHK("ceFreeze", channel_config, channelConfig)
    @(posedge clk);
    #5 calDone = 1'b1;
    @(posedge clk);
    #5 calDone = 1'b0;
    repeat (3) @(posedge clk);
    channel_config[59:58] = 2'h0;
    `CHK("modeCleared", channel_config, channelConfig)
    `CHK("calMode", 3'h0, {calActive, curOpMode})
    scan(1, 1'b1);
    results();
  end
endmodule // adc_serial_config_register_bank_tb

`default_nettype wire
